// ===== rtl/qmx_switch_ctrl.sv
// Two-wire slave that decodes command words into eight mux switch controls
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Slave only; serial clock is an input and is never driven.
// - Start is data falling with clock high; then address MSB first and direction.
// - Matching address gets data held low in the ninth pulse; others stay idle.
// - Direction one reads from the slave, zero writes to it.
// - Every byte is eight data pulses plus one acknowledge pulse.
// - Data changes only with clock low; data rising with clock high is stop.
// - Address is fixed 1010 above three address select pins.
// - A write carries a sixteen bit command word as two bytes.
// - Load strobe and soft reset come from the second command byte.
// - Bit 7 gives closed level; selectors 0 and 1 hit all A or B.
// - Selectors 2 to 9 hit single switches mux1 A through mux4 B.
// - Selectors 14 to 17 open one mux; 31 with bit 7 low opens all.
// - Selector 20 sets the logic output on the variant that has it.
// - Several pending commands on one element: only the latest takes effect.
// - Commands stay pending until a word with load strobe high applies all.
// - Soft reset low or power-up opens all switches and drives output low.
// - Read returns two status bytes; one means closed or output high.
// - Status bits 15..8 are the switches, bit 3 the logic output.
module qmx_switch_ctrl
  import qmx_pkg::*;
#(
  parameter int LOAD_BIT_POS = QMX_LOAD_POS,
  parameter int RESET_BIT_POS = QMX_RESET_POS
) (
  input logic sys_clk_in,
  input logic resetn_in,
  input logic scl_in,
  input logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input logic addr_sel_lsb_in,
  input logic addr_sel_mid_in,
  input logic addr_sel_msb_in,
  output qmx_out_state_t switch_state_out,
  input logic [QMX_AXI_AW-1:0] s_axi_awaddr_in,
  input logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input logic [31:0] s_axi_wdata_in,
  input logic [3:0] s_axi_wstrb_in,
  input logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input logic s_axi_bready_in,
  input logic [QMX_AXI_AW-1:0] s_axi_araddr_in,
  input logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input logic s_axi_rready_in
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic qmx_elem_upd_t qmx_decode(input qmx_cmd_t c, input logic gpo_ok);
    qmx_elem_upd_t u;
    logic [6:0] k;
    u = '0;
    k = '0;
    if (c.selector == QMX_SEL_ALL_A) begin
      u.mask = {1'b0, QMX_MASK_ALL_A};
      u.val = {9{c.cmd_level_bit}};
    end else if (c.selector == QMX_SEL_ALL_B) begin
      u.mask = {1'b0, QMX_MASK_ALL_B};
      u.val = {9{c.cmd_level_bit}};
    end else if (c.selector >= QMX_SEL_ONE_FIRST && c.selector <= QMX_SEL_ONE_LAST) begin
      k = QMX_SEL_ONE_LAST - c.selector;
      u.mask[k[2:0]] = 1'b1;
      u.val = {9{c.cmd_level_bit}};
    end else if (c.selector >= QMX_SEL_OFF_FIRST && c.selector <= QMX_SEL_OFF_LAST) begin
      k = c.selector - QMX_SEL_OFF_FIRST;
      u.mask = {1'b0, QMX_MASK_MUX1 >> {k[1:0], 1'b0}};
    end else if (c.selector == QMX_SEL_GPO && gpo_ok) begin
      u.mask[QMX_GPO_IDX] = 1'b1;
      u.val = {9{c.cmd_level_bit}};
    end else if (c.selector == QMX_SEL_ALL_OFF && !c.cmd_level_bit) begin
      u.mask = {1'b0, QMX_MASK_ALL_SW};
    end
    // Any other code leaves the mask empty and so touches nothing
    return u;
  endfunction

  // Later update wins on every element it names
  function automatic logic [8:0] qmx_merge(input logic [8:0] base, input qmx_elem_upd_t u);
    return (base & ~u.mask) | (u.val & u.mask);
  endfunction

  function automatic logic [2:0] qmx_reg_decode(input logic [QMX_AXI_AW-1:0] a);
    logic [2:0] r;
    r = QMX_RSEL_NONE;
    case (a)
      QMX_REG_CTRL: r = QMX_RSEL_CTRL;
      QMX_REG_STATUS: r = QMX_RSEL_STATUS;
      QMX_REG_PENDING: r = QMX_RSEL_PENDING;
      QMX_REG_WORDS: r = QMX_RSEL_WORDS;
      default: r = QMX_RSEL_NONE;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [QMX_SYNC_W-1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic [2:0] addr_sel_s;
  logic scl_q_reg;
  logic sda_q_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_end;
  logic addr_hit;
  qmx_i2c_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic sda_oe_reg;
  logic rw_reg;
  logic byte_idx_reg;
  logic mack_reg;
  qmx_cmd_t cmd_reg;
  logic word_go_reg;
  qmx_elem_upd_t upd;
  qmx_elem_upd_t pend_reg;
  qmx_elem_upd_t pend_next;
  logic [8:0] applied_reg;
  logic soft_n_reg;
  logic [15:0] words_reg;
  logic [15:0] readback;
  logic [1:0] ctrl_reg;
  logic ctrl_en;
  logic ctrl_variant;
  logic aw_held_reg;
  logic w_held_reg;
  logic [QMX_AXI_AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and bus conditions

  qmx_sync #(
    .WIDTH(QMX_SYNC_W)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .async_in({addr_sel_msb_in, addr_sel_mid_in, addr_sel_lsb_in, sda_in, scl_in}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign addr_sel_s = pins_s[4:2];

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
    end
  end

  // Clock line is only observed, never driven
  assign scl_rise = scl_s & ~scl_q_reg;
  assign scl_fall = ~scl_s & scl_q_reg;
  assign start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
  assign stop_det = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
  assign byte_end = scl_fall && (bit_cnt_reg == QMX_BITS_PER_BYTE);
  assign addr_hit = ctrl_en && (rx_reg[7:1] == {QMX_ADDR_FIXED, addr_sel_s});

  ////////////////////////////////////////////////////////////////////////////
  // Serial state machine

  assign tx_next = byte_idx_reg ? readback[QMX_READBACK_SW_LSB-1:0]
                                : readback[QMX_READBACK_SW_LSB +: 8];

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      sda_oe_reg <= 1'b0;
      rw_reg <= 1'b0;
      byte_idx_reg <= 1'b0;
      mack_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
      byte_idx_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_WR_BYTE: begin
          if (scl_rise) begin
            rx_reg <= {rx_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_end) begin
            if (state_reg == ST_ADDR) begin
              if (addr_hit) begin
                sda_oe_reg <= 1'b1;
                rw_reg <= rx_reg[0];
                state_reg <= ST_ADDR_ACK;
              end else begin
                state_reg <= ST_IGNORE;
              end
            end else begin
              sda_oe_reg <= 1'b1;
              byte_idx_reg <= ~byte_idx_reg;
              state_reg <= ST_WR_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              tx_reg <= tx_next;
              sda_oe_reg <= ~tx_next[7];
              byte_idx_reg <= ~byte_idx_reg;
              state_reg <= ST_RD_BYTE;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg <= ST_WR_BYTE;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg <= ST_WR_BYTE;
          end
        end
        ST_RD_BYTE: begin
          if (scl_fall) begin
            if (bit_cnt_reg == QMX_LAST_BIT) begin
              sda_oe_reg <= 1'b0;
              state_reg <= ST_RD_ACK;
            end else begin
              // Data only moves after the clock has gone low
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe_reg <= ~tx_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            mack_reg <= ~sda_s;
          end else if (scl_fall) begin
            if (mack_reg) begin
              tx_reg <= tx_next;
              sda_oe_reg <= ~tx_next[7];
              byte_idx_reg <= ~byte_idx_reg;
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_RD_BYTE;
            end else begin
              state_reg <= ST_IGNORE;
            end
          end
        end
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain: the line is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe_out = sda_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Command capture

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmd_reg <= '0;
    end else if (byte_end && state_reg == ST_WR_BYTE && !byte_idx_reg) begin
      cmd_reg <= qmx_cmd_t'(rx_reg);
    end
  end

  // Second byte done: the word is complete and rx_reg holds the mode byte
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      word_go_reg <= 1'b0;
    end else begin
      word_go_reg <= byte_end && !start_det && state_reg == ST_WR_BYTE && byte_idx_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending store and applied state

  always_comb begin
    upd = qmx_decode(cmd_reg, ctrl_variant);
    pend_next.mask = pend_reg.mask | upd.mask;
    pend_next.val = qmx_merge(pend_reg.val, upd);
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      applied_reg <= '0;
      pend_reg <= '0;
      soft_n_reg <= 1'b0;
      words_reg <= 16'h0000;
    end else if (word_go_reg) begin
      words_reg <= words_reg + 16'h0001;
      soft_n_reg <= rx_reg[RESET_BIT_POS];
      if (!rx_reg[RESET_BIT_POS]) begin
        // Soft reset drops pending work too, so nothing stale survives it
        applied_reg <= '0;
        pend_reg <= '0;
      end else if (rx_reg[LOAD_BIT_POS]) begin
        applied_reg <= qmx_merge(applied_reg, pend_next);
        pend_reg <= '0;
      end else begin
        pend_reg <= pend_next;
      end
    end else if (!ctrl_variant) begin
      applied_reg[QMX_GPO_IDX] <= 1'b0;
    end
  end

  assign switch_state_out = qmx_out_state_t'(applied_reg);

  always_comb begin
    readback = 16'h0000;
    readback[QMX_READBACK_SW_LSB +: 8] = applied_reg[7:0];
    readback[QMX_READBACK_GPO] = applied_reg[QMX_GPO_IDX];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus: write path

  assign ctrl_en = ctrl_reg[QMX_CTRL_EN_BIT];
  assign ctrl_variant = ctrl_reg[QMX_CTRL_VARIANT_BIT];
  assign s_axi_awready_out = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready_out = ~w_held_reg & ~bvalid_reg;
  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= QMX_AXI_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_in;
        wstrb_reg <= s_axi_wstrb_in;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (qmx_reg_decode(awaddr_reg) == QMX_RSEL_CTRL) ? QMX_AXI_OKAY
                                                                    : QMX_AXI_SLVERR;
      end else if (bvalid_reg && s_axi_bready_in) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_reg <= QMX_CTRL_RST;
    end else if (do_write && wstrb_reg[0] && qmx_reg_decode(awaddr_reg) == QMX_RSEL_CTRL) begin
      ctrl_reg <= wdata_reg[1:0];
    end
  end

  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus: read path

  always_comb begin
    rd_mux = 32'h00000000;
    case (qmx_reg_decode(s_axi_araddr_in))
      QMX_RSEL_CTRL: rd_mux = {30'h0, ctrl_reg};
      QMX_RSEL_STATUS: rd_mux = {20'h00000, sda_oe_reg, state_reg != ST_IDLE,
                                 soft_n_reg, applied_reg};
      QMX_RSEL_PENDING: rd_mux = {7'h00, pend_reg.mask, 7'h00, pend_reg.val};
      QMX_RSEL_WORDS: rd_mux = {16'h0000, words_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  assign s_axi_arready_out = ~rvalid_reg;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= QMX_AXI_OKAY;
      rdata_reg <= 32'h00000000;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= (qmx_reg_decode(s_axi_araddr_in) == QMX_RSEL_NONE) ? QMX_AXI_SLVERR
                                                                        : QMX_AXI_OKAY;
    end else if (rvalid_reg && s_axi_rready_in) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign s_axi_rdata_out = rdata_reg;

endmodule

// ===== shared/qmx_pkg.sv
// Constants and types for the quad 2:1 mux switch controller
package qmx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave address and frame shape
  localparam logic [3:0] QMX_ADDR_FIXED = 4'hA;
  localparam logic [3:0] QMX_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] QMX_LAST_BIT = 4'h7;
  localparam int QMX_SYNC_W = 5;

  // Default positions of the mode bits inside the second command byte
  localparam int QMX_LOAD_POS = 0;
  localparam int QMX_RESET_POS = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Selector codes of the first command byte
  localparam logic [6:0] QMX_SEL_ALL_A = 7'h00;
  localparam logic [6:0] QMX_SEL_ALL_B = 7'h01;
  localparam logic [6:0] QMX_SEL_ONE_FIRST = 7'h02;
  localparam logic [6:0] QMX_SEL_ONE_LAST = 7'h09;
  localparam logic [6:0] QMX_SEL_OFF_FIRST = 7'h0E;
  localparam logic [6:0] QMX_SEL_OFF_LAST = 7'h11;
  localparam logic [6:0] QMX_SEL_GPO = 7'h14;
  localparam logic [6:0] QMX_SEL_ALL_OFF = 7'h1F;

  // Element vector: bit 8 is the logic output, bits 7..0 the switches
  localparam int QMX_GPO_IDX = 8;
  localparam logic [7:0] QMX_MASK_ALL_A = 8'hAA;
  localparam logic [7:0] QMX_MASK_ALL_B = 8'h55;
  localparam logic [7:0] QMX_MASK_MUX1 = 8'hC0;
  localparam logic [7:0] QMX_MASK_ALL_SW = 8'hFF;

  // Status word sent back over the serial link
  localparam int QMX_READBACK_SW_LSB = 8;
  localparam int QMX_READBACK_GPO = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus map
  localparam int QMX_AXI_AW = 8;
  localparam logic [7:0] QMX_REG_CTRL = 8'h00;
  localparam logic [7:0] QMX_REG_STATUS = 8'h04;
  localparam logic [7:0] QMX_REG_PENDING = 8'h08;
  localparam logic [7:0] QMX_REG_WORDS = 8'h0C;
  localparam int QMX_CTRL_EN_BIT = 0;
  localparam int QMX_CTRL_VARIANT_BIT = 1;
  localparam logic [1:0] QMX_CTRL_RST = 2'h3;
  localparam logic [1:0] QMX_AXI_OKAY = 2'h0;
  localparam logic [1:0] QMX_AXI_SLVERR = 2'h2;

  // Register decode results
  localparam logic [2:0] QMX_RSEL_NONE = 3'h0;
  localparam logic [2:0] QMX_RSEL_CTRL = 3'h1;
  localparam logic [2:0] QMX_RSEL_STATUS = 3'h2;
  localparam logic [2:0] QMX_RSEL_PENDING = 3'h3;
  localparam logic [2:0] QMX_RSEL_WORDS = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic cmd_level_bit;
    logic [6:0] selector;
  } qmx_cmd_t;

  typedef struct packed {
    logic [8:0] mask;
    logic [8:0] val;
  } qmx_elem_upd_t;

  typedef struct packed {
    logic gp_logic_output;
    logic [7:0] closed;
  } qmx_out_state_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_BYTE,
    ST_WR_ACK,
    ST_RD_BYTE,
    ST_RD_ACK,
    ST_IGNORE
  } qmx_i2c_state_t;

endpackage

// ===== rtl/qmx_sync.sv
// Two-flop synchroniser for the serial pins and address select inputs
`timescale 1ns/1ps
module qmx_sync
  import qmx_pkg::*;
#(
  parameter int WIDTH = QMX_SYNC_W
) (
  input logic sys_clk_in,
  input logic resetn_in,
  input logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Idle bus lines float high, so reset to ones to avoid a false start
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

// ===== sim/qmx_switch_ctrl_props.sv
// Port-level checker for the mux switch controller
`timescale 1ns/1ps
module qmx_switch_ctrl_props (
  input logic sys_clk_in,
  input logic resetn_in,
  input logic scl_in,
  input logic sda_in,
  input logic sda_out,
  input logic sda_oe_out,
  input logic s_axi_awvalid_in,
  input logic s_axi_awready_out,
  input logic s_axi_wvalid_in,
  input logic s_axi_wready_out,
  input logic s_axi_bvalid_out,
  input logic s_axi_bready_in,
  input logic s_axi_arvalid_in,
  input logic s_axi_arready_out,
  input logic s_axi_rvalid_out,
  input logic s_axi_rready_in
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  ////////////////////////////////////////
  sequence wr_taken;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence bus_stop;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  sda_low_only_a: assert property (sda_out == 1'h0)
    else $error("data pin driven high");
  stop_release_a: assert property (bus_stop |-> ##[1:6] !sda_oe_out)
    else $error("data pin held after stop");
  oe_steady_a: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data pin moved while clock high");
  b_after_wr_a: assert property (wr_taken |-> ##2 s_axi_bvalid_out)
    else $error("write response late");
  b_refuse_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken during response");
  b_drop_a: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
    else $error("write response not cleared");
  r_after_ar_a: assert property (s_axi_arvalid_in && s_axi_arready_out
    |=> s_axi_rvalid_out && !s_axi_arready_out)
    else $error("read answer late");
  r_drop_a: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
    else $error("read answer not cleared");
endmodule

// ===== sim/qmx_i2c_master.sv
// Behavioural two-wire bus master facing the controller
`timescale 1ns/1ps
module qmx_i2c_master (
  input logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // Clock idles high between frames
  initial begin
    scl_out = 1'h1;
    sda_low_out = 1'h0;
  end
  ////////////////////////////////////////
  task automatic bit_xfer(input logic b, output logic r);
    #50 sda_low_out = ~b;
    #50 scl_out = 1'h1;
    #50 r = sda_in;
    #50 scl_out = 1'h0;
  endtask
  task automatic start();
    sda_low_out = 1'h1;
    #100 scl_out = 1'h0;
  endtask
  // Low before the tenth pulse, then high while clock is high
  task automatic stop();
    #50 sda_low_out = 1'h1;
    #50 scl_out = 1'h1;
    #100 sda_low_out = 1'h0;
    #100;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'h1, ack);
  endtask
  task automatic rd_byte(output logic [7:0] d, input logic nack);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_xfer(1'h1, r);
      d = {d[6:0], r};
    end
    bit_xfer(nack, r);
  endtask
endmodule

// ===== sim/qmx_switch_ctrl_test.sv
// Self-checking bench for the mux switch controller
`timescale 1ns/1ps
module qmx_switch_ctrl_test;
  import qmx_pkg::*;
  logic sys_clk_in = 1'h0;
  logic resetn_in = 1'h0;
  logic scl, sda_low, sda_oe, sda_drv, sda;
  qmx_out_state_t sw;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
  logic awr, wr, bv, arr, rv;
  logic [1:0] bresp, rresp;
  int n_mismatch = 0;
  int n_compared = 0;
  always #12.5 sys_clk_in = ~sys_clk_in;
  // Open-drain line with pull-up
  assign sda = sda_oe ? sda_drv : ~sda_low;
  qmx_i2c_master qmx_i2c_master_inst (.sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
  qmx_switch_ctrl qmx_switch_ctrl_inst (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_drv), .sda_oe_out(sda_oe),
    .addr_sel_lsb_in(1'h1), .addr_sel_mid_in(1'h0), .addr_sel_msb_in(1'h1),
    .switch_state_out(sw), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rready));
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk_in);
    awaddr <= a;
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge sys_clk_in);
      if (awr) awv <= 1'h0;
      if (wr) wv <= 1'h0;
    end while (!bv);
    bready <= 1'h0;
    check("bresp", bresp, er);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk_in);
    araddr <= a;
    arv <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge sys_clk_in);
      if (arr) arv <= 1'h0;
    end while (!rv);
    rready <= 1'h0;
    check("rdata", rdata, ed);
    check("rresp", rresp, er);
  endtask
  // Address pins give 1010101, write byte AA, read byte AB
  task automatic send_word(input logic [7:0] c, input logic [7:0] m, input logic [8:0] e);
    logic [2:0] k;
    // Serial edges land on falling clock edges, clear of the sampling edge
    @(negedge sys_clk_in);
    qmx_i2c_master_inst.start();
    qmx_i2c_master_inst.wr_byte(8'hAA, k[2]);
    qmx_i2c_master_inst.wr_byte(c, k[1]);
    qmx_i2c_master_inst.wr_byte(m, k[0]);
    qmx_i2c_master_inst.stop();
    check("ack", k, 3'h0);
    check("state", sw, e);
  endtask
  task automatic read_back(input logic [15:0] e);
    logic [15:0] d;
    logic k;
    @(negedge sys_clk_in);
    qmx_i2c_master_inst.start();
    qmx_i2c_master_inst.wr_byte(8'hAB, k);
    qmx_i2c_master_inst.rd_byte(d[15:8], 1'h0);
    qmx_i2c_master_inst.rd_byte(d[7:0], 1'h1);
    qmx_i2c_master_inst.stop();
    check("readback", {k, d}, {1'h0, e});
  endtask
  task automatic probe(input logic [7:0] a);
    logic k;
    @(negedge sys_clk_in);
    qmx_i2c_master_inst.start();
    qmx_i2c_master_inst.wr_byte(a, k);
    qmx_i2c_master_inst.stop();
    check("no_ack", k, 1'h1);
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #(80000 * 25);
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge sys_clk_in);
    resetn_in <= 1'h1;
    repeat (4) @(posedge sys_clk_in);
    check("state", sw, 9'h000);
    axi_rd(QMX_REG_CTRL, 32'h3, QMX_AXI_OKAY);
    axi_rd(8'h10, 32'h0, QMX_AXI_SLVERR);
    axi_wr(QMX_REG_STATUS, 32'h1, QMX_AXI_SLVERR);
    for (int s = 2; s <= 9; s++) begin
      send_word({1'h1, 7'(s)}, 8'h03, 9'(1 << (9 - s)));
      send_word({1'h0, 7'(s)}, 8'h03, 9'h000);
    end
    send_word(8'h80, 8'h03, 9'h0AA);
    send_word(8'h0E, 8'h03, 9'h02A);
    send_word(8'h8F, 8'h03, 9'h00A);
    send_word(8'h10, 8'h03, 9'h002);
    send_word(8'h11, 8'h03, 9'h000);
    send_word(8'h81, 8'h03, 9'h055);
    send_word(8'h9F, 8'h03, 9'h055);
    send_word(8'h8A, 8'h03, 9'h055);
    send_word(8'h1F, 8'h03, 9'h000);
    send_word(8'h82, 8'h02, 9'h000);
    send_word(8'h02, 8'h02, 9'h000);
    send_word(8'h84, 8'h02, 9'h000);
    send_word(8'h94, 8'h03, 9'h120);
    read_back(16'h2008);
    axi_rd(QMX_REG_STATUS, 32'h320, QMX_AXI_OKAY);
    send_word(8'h00, 8'h01, 9'h000);
    axi_wr(QMX_REG_CTRL, 32'h1, QMX_AXI_OKAY);
    send_word(8'h94, 8'h02, 9'h000);
    axi_rd(QMX_REG_PENDING, 32'h0, QMX_AXI_OKAY);
    send_word(8'h94, 8'h03, 9'h000);
    axi_wr(QMX_REG_CTRL, 32'h0, QMX_AXI_OKAY);
    probe(8'hAA);
    axi_wr(QMX_REG_CTRL, 32'h3, QMX_AXI_OKAY);
    probe(8'hA0);
    read_back(16'h0000);
    close_out();
  end
endmodule
bind qmx_switch_ctrl qmx_switch_ctrl_props qmx_switch_ctrl_props_inst (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in));
